// *** rtl/cirm_top.sv ***
// Consumer infrared modem configuration and carrier modulator
// ======================================================================
`timescale 1ns/10ps
`default_nettype none
module cirm_top
    import cirm_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    input  wire logic [5:0]  awaddr_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    output logic [1:0]       bresp_out,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    input  wire logic [5:0]  araddr_in,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    output logic [31:0]      rdata_out,
    output logic [1:0]       rresp_out,
    output logic             rvalid_out,
    input  wire logic        rready_in,
    input  wire logic        tx_bit_in,
    input  wire logic        tx_bit_strobe_in,
    input  wire logic        pulse_mode_in,
    input  wire logic [3:0]  id_pins_in,
    input  wire logic        id_select_rx2_pin_in,
    output logic             id_select_rx2_pin_out,
    output logic             id_select_rx2_pin_oe_out,
    output logic             ir_tx_out,
    output logic             demod_enable_out,
    output logic             rx_high_range_out,
    output logic             rx_oversample_out
);
    // ==================================================================
    // Registers
    cirm_cfg_type     consumer_ir_config;
    logic [7:0]       tx_mod_ctrl;
    logic [7:0]       line_ctrl_bank_select;
    logic [7:0]       transceiver_config_four;
    logic             xcvr_id_ctrl_bit0;
    logic [7:0]       rle_code;
    cirm_carrier_type timing;
    logic [7:0]       rle_enc;
    logic             rle_bit;
    logic [7:0]       rle_run;
    logic [7:0]       run_count;
    logic             run_bit;

    logic aw_hold, w_hold;
    logic [5:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        auto_cfg, pin_dir_out;

    assign auto_cfg    = transceiver_config_four[CIRM_AUTO_BIT];
    assign pin_dir_out = transceiver_config_four[CIRM_DIR0_BIT];
    assign do_write    = aw_hold && w_hold && !bvalid_out;

    // ==================================================================
    // Write channel: address and data taken in either order
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 6'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid_out <= 1'b0;
            bresp_out  <= CIRM_RESP_OK;
        end else if (ce_in) begin
            if (awvalid_in && !aw_hold) begin
                aw_hold <= 1'b1;
                aw_addr <= awaddr_in;
            end
            if (wvalid_in && !w_hold) begin
                w_hold <= 1'b1;
                w_data <= wdata_in;
                w_strb <= wstrb_in;
            end
            if (do_write) begin
                aw_hold    <= 1'b0;
                w_hold     <= 1'b0;
                bvalid_out <= 1'b1;
                case (aw_addr)
                    CIRM_CFG_ADDR, CIRM_TXMC_ADDR, CIRM_XC1_ADDR,
                    CIRM_XC4_ADDR, CIRM_LCBS_ADDR, CIRM_RLE_ADDR:
                        bresp_out <= CIRM_RESP_OK;
                    default: bresp_out <= CIRM_RESP_ERR;
                endcase
            end else if (bvalid_out && bready_in) begin
                bvalid_out <= 1'b0;
            end
        end
    end
    // Ready only while the clock enable lets the capture happen
    assign awready_out = !aw_hold && !srst_in && ce_in;
    assign wready_out  = !w_hold && !srst_in && ce_in;

    // ==================================================================
    // Register updates
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            consumer_ir_config      <= CIRM_CFG_RST;
            tx_mod_ctrl             <= CIRM_TXMC_RST;
            line_ctrl_bank_select   <= CIRM_LCBS_RST;
            transceiver_config_four <= CIRM_XC4_RST;
            xcvr_id_ctrl_bit0       <= 1'b0;
            rle_code                <= CIRM_LCBS_RST;
        end else if (ce_in && do_write && w_strb[0]) begin
            case (aw_addr)
                // Reserved bit 3 is never stored
                CIRM_CFG_ADDR:
                    consumer_ir_config <= w_data[7:0] & CIRM_CFG_WMASK;
                CIRM_TXMC_ADDR: tx_mod_ctrl <= w_data[7:0];
                CIRM_LCBS_ADDR: line_ctrl_bank_select <= w_data[7:0];
                CIRM_XC4_ADDR:
                    transceiver_config_four <= w_data[7:0] & CIRM_XC4_WMASK;
                CIRM_XC1_ADDR:
                    // Input pin: write ignored
                    if (pin_dir_out)
                        xcvr_id_ctrl_bit0 <= w_data[0];
                CIRM_RLE_ADDR: rle_code <= w_data[7:0];
                default: ;
            endcase
        end
    end

    // ==================================================================
    // Read channel
    logic [7:0] rd_byte;
    logic       rd_ok;
    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        case (araddr_in)
            CIRM_CFG_ADDR:  rd_byte = consumer_ir_config;
            CIRM_TXMC_ADDR: rd_byte = tx_mod_ctrl;
            CIRM_LCBS_ADDR: rd_byte = line_ctrl_bank_select;
            CIRM_XC4_ADDR:  rd_byte = transceiver_config_four;
            // Pin level or written value; id pins 3..1 on bits 3..1
            CIRM_XC1_ADDR:  rd_byte = {4'h0, id_pins_in[3:1],
                pin_dir_out ? xcvr_id_ctrl_bit0 : id_select_rx2_pin_in};
            CIRM_MODE_ADDR: rd_byte = {7'h00, timing.valid};
            CIRM_STAT_ADDR: rd_byte = run_count;
            CIRM_RLE_ADDR:  rd_byte = {rle_bit, 7'(rle_run - 8'h01)};
            default: rd_ok = 1'b0;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rvalid_out <= 1'b0;
            rdata_out  <= 32'h0000_0000;
            rresp_out  <= CIRM_RESP_OK;
        end else if (ce_in) begin
            if (arvalid_in && arready_out) begin
                rvalid_out <= 1'b1;
                rdata_out  <= {24'h000000, rd_byte};
                rresp_out  <= rd_ok ? CIRM_RESP_OK : CIRM_RESP_ERR;
            end else if (rvalid_out && rready_in) begin
                rvalid_out <= 1'b0;
            end
        end
    end
    assign arready_out = !rvalid_out && !srst_in && ce_in;

    // ==================================================================
    // Lookup and run-length helpers
    cirm_carrier_lut u_lut (
        .high_in       (consumer_ir_config.tx_high_range_sel),
        .freq_code_in  (tx_mod_ctrl[4:0]),
        .width_code_in (tx_mod_ctrl[7:5]),
        .timing_out    (timing)
    );
    cirm_rle_codec u_rle (
        .bit_in   (run_bit),
        .run_in   (run_count),
        .code_in  (rle_code),
        .code_out (rle_enc),
        .bit_out  (rle_bit),
        .run_out  (rle_run)
    );

    // Run tracking of transmitted bits, restarting at one after the longest code
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            run_count <= 8'h00;
            run_bit   <= 1'b1;
        end else if (ce_in && tx_bit_strobe_in
                     && consumer_ir_config.run_length_enable) begin
            if (tx_bit_in != run_bit || run_count == 8'(CIRM_RUN_MAX))
                run_count <= 8'h01;
            else
                run_count <= run_count + 8'h01;
            run_bit <= tx_bit_in;
        end
    end

    // ==================================================================
    // Carrier modulator
    logic        prev_bit;
    logic        cur_bit;
    logic [15:0] phase;
    logic [3:0]  burst_left;
    logic        carrier_on;
    cirm_mod_type mode;
    assign mode = cirm_mod_type'(consumer_ir_config.tx_modulation_mode);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prev_bit   <= 1'b1;
            cur_bit    <= 1'b1;
            burst_left <= 4'h0;
        end else if (ce_in) begin
            if (tx_bit_strobe_in) begin
                prev_bit <= tx_bit_in;
                cur_bit  <= tx_bit_in;
                if (!tx_bit_in && prev_bit) begin
                    case (mode)
                        CIRM_MOD_EIGHT: burst_left <= 4'(CIRM_BURST8);
                        CIRM_MOD_SIX:   burst_left <= 4'(CIRM_BURST6);
                        default:        burst_left <= 4'h0;
                    endcase
                end
            end else if (phase >= timing.half_period - 16'h0001
                         && burst_left != 4'h0) begin
                burst_left <= burst_left - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || !timing.valid) begin
            phase <= 16'h0000;
        end else if (ce_in) begin
            // Restart at each bit so a burst is made of whole pulses only
            if (tx_bit_strobe_in
                || phase >= timing.half_period - 16'h0001)
                phase <= 16'h0000;
            else
                phase <= phase + 16'h0001;
        end
    end

    always_comb begin
        case (mode)
            CIRM_MOD_CONT:  carrier_on = !cur_bit;
            CIRM_MOD_EIGHT,
            CIRM_MOD_SIX:   carrier_on = burst_left != 4'h0;
            default:        carrier_on = 1'b0; // Undefined mode kept quiet
        endcase
    end

    // ==================================================================
    // Outputs
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ir_tx_out                <= 1'b0;
            id_select_rx2_pin_out    <= 1'b0;
            id_select_rx2_pin_oe_out <= 1'b0;
            demod_enable_out         <= 1'b1;
            rx_high_range_out        <= 1'b0;
            rx_oversample_out        <= 1'b0;
        end else if (ce_in) begin
            ir_tx_out <= carrier_on && timing.valid
                && (phase < {6'h00, timing.pulse_len});
            // Drive only in pulse mode when auto config on
            id_select_rx2_pin_oe_out <= pin_dir_out
                && (!auto_cfg || pulse_mode_in);
            id_select_rx2_pin_out <= xcvr_id_ctrl_bit0;
            demod_enable_out  <= !consumer_ir_config.demod_disable;
            rx_high_range_out <= consumer_ir_config.rx_high_range_sel;
            rx_oversample_out <= consumer_ir_config.rx_sampling_sel;
        end
    end

    // ==================================================================
    // Checks
    cfg_reset_a: assert property (@(posedge clk_in)
        srst_in |=> consumer_ir_config == CIRM_CFG_RST)
        else $error("config not cleared");
    rsvd_zero_a: assert property (@(posedge clk_in) disable iff (srst_in)
        consumer_ir_config.rsvd == 1'b0)
        else $error("reserved bit set");
    demod_follow_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in |=> demod_enable_out == !$past(consumer_ir_config.demod_disable))
        else $error("demod enable wrong");
    pin_input_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !pin_dir_out |=> !id_select_rx2_pin_oe_out || !ce_in)
        else $error("pin driven while input");
    auto_gate_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && pin_dir_out && auto_cfg && !pulse_mode_in
        |=> !id_select_rx2_pin_oe_out)
        else $error("auto drive outside mode");
    manual_drive_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && pin_dir_out && !auto_cfg |=> id_select_rx2_pin_oe_out)
        else $error("manual drive missing");
    cont_quiet_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && mode == CIRM_MOD_CONT && cur_bit |=> !ir_tx_out)
        else $error("carrier on a one bit");
    burst_load_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && tx_bit_strobe_in && !tx_bit_in && prev_bit
        && mode == CIRM_MOD_SIX |=> burst_left == 4'(CIRM_BURST6))
        else $error("six burst not loaded");
    burst8_load_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && tx_bit_strobe_in && !tx_bit_in && prev_bit
        && mode == CIRM_MOD_EIGHT |=> burst_left == 4'(CIRM_BURST8))
        else $error("eight burst not loaded");
    cov_write_c: cover property (@(posedge clk_in) bvalid_out && bready_in);
    cov_read_c: cover property (@(posedge clk_in) rvalid_out && rready_in);
    cov_burst_c: cover property (@(posedge clk_in) burst_left == 4'h1);
    cov_tx_c: cover property (@(posedge clk_in) ir_tx_out);
endmodule : cirm_top
`default_nettype wire

// *** rtl/cirm_pkg.sv ***
// Package: constants and types for the consumer infrared modem configuration
package cirm_pkg;
    // ==================================================================
    // Register byte addresses
    localparam logic [5:0] CIRM_LCBS_ADDR = 6'h0c;
    localparam logic [5:0] CIRM_CFG_ADDR  = 6'h00;
    localparam logic [5:0] CIRM_TXMC_ADDR = 6'h04;
    localparam logic [5:0] CIRM_XC1_ADDR  = 6'h08;
    localparam logic [5:0] CIRM_XC4_ADDR  = 6'h10;
    localparam logic [5:0] CIRM_MODE_ADDR = 6'h14;
    localparam logic [5:0] CIRM_STAT_ADDR = 6'h18;
    localparam logic [5:0] CIRM_RLE_ADDR  = 6'h1c;
    // ==================================================================
    // Reset values
    localparam logic [7:0] CIRM_CFG_RST  = 8'h00;
    localparam logic [7:0] CIRM_TXMC_RST = 8'h69;
    localparam logic [7:0] CIRM_XC4_RST  = 8'h00;
    localparam logic [7:0] CIRM_LCBS_RST = 8'h00;
    localparam logic [7:0] CIRM_XC1_RST  = 8'h00;
    // Writable masks
    localparam logic [7:0] CIRM_CFG_WMASK = 8'hf7;
    localparam logic [7:0] CIRM_XC4_WMASK = 8'hb8;
    // ==================================================================
    // Field positions
    localparam int CIRM_TXHI_BIT  = 2;
    localparam int CIRM_DDIS_BIT  = 4;
    localparam int CIRM_RXHI_BIT  = 5;
    localparam int CIRM_OVS_BIT   = 6;
    localparam int CIRM_RLEN_BIT  = 7;
    localparam int CIRM_DIR0_BIT  = 5;
    localparam int CIRM_AUTO_BIT  = 7;
    // ==================================================================
    // Carrier codes
    localparam logic [4:0] CIRM_LO_MIN = 5'h03;
    localparam logic [4:0] CIRM_LO_MAX = 5'h1e;
    localparam logic [4:0] CIRM_HI_400 = 5'h03;
    localparam logic [4:0] CIRM_HI_450 = 5'h08;
    localparam logic [4:0] CIRM_HI_480 = 5'h0b;
    localparam int CIRM_CLK_KHZ = 40000;
    localparam int CIRM_LO_BASE_KHZ = 27;
    localparam int CIRM_KHZ_569 = 569; // tenths of kHz, code 11110
    localparam int CIRM_BURST8 = 8;
    localparam int CIRM_BURST6 = 6;
    localparam int CIRM_RUN_MAX = 128;
    localparam logic [1:0] CIRM_RESP_OK  = 2'b00;
    localparam logic [1:0] CIRM_RESP_ERR = 2'b10;

    typedef enum logic [1:0] {
        CIRM_MOD_CONT, CIRM_MOD_EIGHT, CIRM_MOD_SIX, CIRM_MOD_RSVD
    } cirm_mod_type;

    typedef struct packed {
        logic       run_length_enable;
        logic       rx_sampling_sel;
        logic       rx_high_range_sel;
        logic       demod_disable;
        logic       rsvd;
        logic       tx_high_range_sel;
        logic [1:0] tx_modulation_mode;
    } cirm_cfg_type;

    typedef struct packed {
        logic [15:0] half_period;
        logic [9:0]  pulse_len;
        logic        valid;
    } cirm_carrier_type;
endpackage : cirm_pkg

// *** rtl/cirm_carrier_lut.sv ***
// Carrier timing lookup: frequency and pulse width codes to cycle counts
`timescale 1ns/10ps
`default_nettype none
module cirm_carrier_lut
    import cirm_pkg::*;
(
    input  wire logic                   high_in,
    input  wire logic [4:0]             freq_code_in,
    input  wire logic [2:0]             width_code_in,
    output cirm_pkg::cirm_carrier_type  timing_out
);
    // ==================================================================
    // Decode
    int period_cyc;
    int width_ns;
    always_comb begin
        period_cyc = 0;
        width_ns   = 0;
        if (!high_in) begin
            // Low range: 30..56 kHz by 1 kHz, then 56.9 kHz
            if (freq_code_in == CIRM_LO_MAX)
                period_cyc = (CIRM_CLK_KHZ * 10) / CIRM_KHZ_569;
            else if (freq_code_in >= CIRM_LO_MIN && freq_code_in < CIRM_LO_MAX)
                period_cyc = CIRM_CLK_KHZ
                    / (CIRM_LO_BASE_KHZ + int'(freq_code_in));
            case (width_code_in)
                3'h2: width_ns = 6000;
                3'h3: width_ns = 7000;
                3'h4: width_ns = 9000;
                3'h5: width_ns = 10600;
                default: width_ns = 0;
            endcase
        end else begin
            case (freq_code_in)
                CIRM_HI_400: period_cyc = CIRM_CLK_KHZ / 400;
                CIRM_HI_450: period_cyc = CIRM_CLK_KHZ / 450;
                CIRM_HI_480: period_cyc = CIRM_CLK_KHZ / 480;
                default:     period_cyc = 0;
            endcase
            case (width_code_in)
                3'h2: width_ns = 700;
                3'h3: width_ns = 800;
                3'h4: width_ns = 900;
                default: width_ns = 0;
            endcase
        end
        timing_out.half_period = 16'(period_cyc);
        timing_out.pulse_len   = 10'(width_ns / 25);
        timing_out.valid = (period_cyc != 0) && (width_ns != 0);
    end
endmodule : cirm_carrier_lut
`default_nettype wire

// *** rtl/cirm_rle_codec.sv ***
// Run-length code byte packer and unpacker
`timescale 1ns/10ps
`default_nettype none
module cirm_rle_codec
    import cirm_pkg::*;
(
    input  wire logic       bit_in,
    input  wire logic [7:0] run_in,
    input  wire logic [7:0] code_in,
    output logic [7:0]      code_out,
    output logic            bit_out,
    output logic [7:0]      run_out
);
    // ==================================================================
    // Top bit is the value, low seven the run minus one
    always_comb begin
        code_out = {bit_in, 7'(run_in - 8'h01)};
        bit_out  = code_in[7];
        run_out  = {1'b0, code_in[6:0]} + 8'h01;
    end
endmodule : cirm_rle_codec
`default_nettype wire

// *** verif/cirm_xcvr_model.sv ***
// Behavioural model of the external infrared optical transceiver
`timescale 1ns/10ps
`default_nettype none
module cirm_xcvr_model (
    input  wire logic       clk_in,
    input  wire logic       clr_in,
    input  wire logic       ir_tx_in,
    input  wire logic       pin_drv_in,
    input  wire logic       pin_oe_in,
    input  wire logic [3:0] id_lvl_in,
    output logic            pin_level_out,
    output logic [3:0]      id_pins_out,
    output logic [7:0]      pulse_count_out
);
    // ==================================================================
    // Shared pin: adaptor drives its id level only while the block listens
    logic last_tx;
    assign pin_level_out = pin_oe_in ? pin_drv_in : id_lvl_in[0];
    assign id_pins_out   = id_lvl_in;
    // ==================================================================
    // Light pulses counted as rising edges of the carrier
    always_ff @(posedge clk_in) begin
        last_tx <= ir_tx_in;
        if (clr_in) begin
            pulse_count_out <= 8'h00;
        end else if (ir_tx_in && !last_tx) begin
            pulse_count_out <= pulse_count_out + 8'h01;
        end
    end
endmodule : cirm_xcvr_model
`default_nettype wire

// *** verif/consumer_ir_modem_config_tb.sv ***
// Self-checking bench for the consumer infrared modem configuration
`timescale 1ns/10ps
`default_nettype none
module consumer_ir_modem_config_tb;
    import cirm_pkg::*;
    typedef struct packed {
        logic [7:0] wr;
        logic [7:0] rd;
        logic [2:0] lvl;
    } cirm_row_type;
    localparam int BIT_CYC = 2000;
    logic         clk_in, srst_in, awvalid, wvalid, bready, arvalid, rready;
    logic [5:0]   awaddr, araddr;
    logic [31:0]  wdata, rdata, rd;
    logic         tx_bit, tx_strobe, pulse_mode, clr, pin_lvl;
    logic [3:0]   id_lvl, id_pins;
    logic [7:0]   pulses;
    logic         awready, wready, bvalid, arready, rvalid;
    logic         pin_drv, pin_oe, ir_tx, demod_en, rx_hi, rx_ovs;
    logic [1:0]   bresp, rresp, resp;
    int           err_count, samples_checked, m, lo, hi;
    cirm_row_type rows [6];
    // ==================================================================
    // Design and transceiver
    cirm_top i_dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
        .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
        .wdata_in(wdata), .wstrb_in(4'h1), .wvalid_in(wvalid),
        .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
        .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
        .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
        .rvalid_out(rvalid), .rready_in(rready), .tx_bit_in(tx_bit),
        .tx_bit_strobe_in(tx_strobe), .pulse_mode_in(pulse_mode),
        .id_pins_in(id_pins), .id_select_rx2_pin_in(pin_lvl),
        .id_select_rx2_pin_out(pin_drv), .id_select_rx2_pin_oe_out(pin_oe),
        .ir_tx_out(ir_tx), .demod_enable_out(demod_en),
        .rx_high_range_out(rx_hi), .rx_oversample_out(rx_ovs));
    cirm_xcvr_model i_xcvr (.clk_in(clk_in), .clr_in(clr), .ir_tx_in(ir_tx),
        .pin_drv_in(pin_drv), .pin_oe_in(pin_oe), .id_lvl_in(id_lvl),
        .pin_level_out(pin_lvl), .id_pins_out(id_pins),
        .pulse_count_out(pulses));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // ==================================================================
    // Reporting
    task complete_run;
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_val
    task chk_resp(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t resp %h exp %h", $time, got, exp);
        end
    endtask : chk_resp
    // ==================================================================
    // Bus cycles; every wait is bounded
    task axi_wr(input logic [5:0] a, input logic [7:0] d);
        int n;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) begin
            err_count++;
            complete_run();
        end
        chk_resp(bresp, CIRM_RESP_OK);
        bready <= 1'b0;
        @(posedge clk_in);
    endtask : axi_wr
    task axi_rd(input logic [5:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) begin
            err_count++;
            complete_run();
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk_in);
    endtask : axi_rd
    task send_bit(input logic b);
        tx_bit <= b;
        tx_strobe <= 1'b1;
        @(posedge clk_in);
        tx_strobe <= 1'b0;
        repeat (BIT_CYC - 1) @(posedge clk_in);
    endtask : send_bit
    // ==================================================================
    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, tx_bit, tx_strobe} = '0;
        {awaddr, araddr, wdata, pulse_mode, clr} = '0;
        id_lvl = 4'b1011;
        srst_in = 1'b1;
        // Software settings keep disable set with oversampling
        rows = '{'{8'hfe, 8'hf6, 3'b011}, '{8'h10, 8'h10, 3'b000},
                 '{8'h20, 8'h20, 3'b110}, '{8'h50, 8'h50, 3'b001},
                 '{8'h08, 8'h00, 3'b100}, '{8'h80, 8'h80, 3'b100}};
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        chk_val({30'h0, demod_en, ir_tx}, 32'h2);
        axi_rd(CIRM_CFG_ADDR);
        chk_val(rd, 32'h0);
        foreach (rows[i]) begin
            axi_wr(CIRM_CFG_ADDR, rows[i].wr);
            axi_rd(CIRM_CFG_ADDR);
            chk_val(rd, {24'h0, rows[i].rd});
            chk_val({demod_en, rx_hi, rx_ovs}, rows[i].lvl);
        end
        axi_rd(6'h3c);
        chk_resp(resp, CIRM_RESP_ERR);
        axi_wr(CIRM_LCBS_ADDR, 8'h5a);
        axi_rd(CIRM_LCBS_ADDR);
        chk_val(rd, 32'h5a);
        axi_wr(CIRM_RLE_ADDR, 8'h85);
        axi_rd(CIRM_RLE_ADDR);
        chk_val(rd, 32'h85);
        // Pin as input: reads follow the adaptor, writes dropped
        axi_wr(CIRM_XC1_ADDR, 8'h00);
        axi_rd(CIRM_XC1_ADDR);
        chk_val(rd, {28'h0, id_lvl});
        chk_val(pin_oe, 1'b0);
        axi_wr(CIRM_XC4_ADDR, 8'h20);
        axi_wr(CIRM_XC1_ADDR, 8'h01);
        chk_val({pin_oe, pin_drv}, 2'b11);
        axi_wr(CIRM_XC1_ADDR, 8'h00);
        axi_rd(CIRM_XC1_ADDR);
        chk_val(rd, {28'h0, id_lvl[3:1], 1'b0});
        axi_wr(CIRM_XC4_ADDR, 8'ha0);
        chk_val(pin_oe, 1'b0);
        pulse_mode <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk_val(pin_oe, 1'b1);
        // High range 480 kHz, 0.7 us pulses; mode 11 is never written
        axi_wr(CIRM_TXMC_ADDR, 8'h4b);
        for (m = 0; m < 3; m++) begin
            axi_wr(CIRM_CFG_ADDR, 8'h04 | m[7:0]);
            send_bit(1'b1);
            clr <= 1'b1;
            @(posedge clk_in);
            clr <= 1'b0;
            send_bit(1'b0);
            send_bit(1'b0);
            lo = (m == 0) ? 2 * BIT_CYC * 480 / CIRM_CLK_KHZ - 1 :
                 (m == 1) ? CIRM_BURST8 : CIRM_BURST6;
            hi = (m == 0) ? lo + 2 : lo;
            chk_val(pulses >= lo && pulses <= hi, 32'h1);
        end
        // Reserved frequency and width codes give no carrier
        for (m = 0; m < 2; m++) begin
            axi_wr(CIRM_CFG_ADDR, (m == 0) ? 8'h00 : 8'h04);
            axi_wr(CIRM_TXMC_ADDR, (m == 0) ? 8'h60 : 8'hab);
            clr <= 1'b1;
            @(posedge clk_in);
            clr <= 1'b0;
            send_bit(1'b0);
            chk_val(pulses, 32'h0);
        end
        // Reset again in mid-run: configuration must clear
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        chk_val({30'h0, demod_en, ir_tx}, 32'h2);
        axi_rd(CIRM_CFG_ADDR);
        chk_val(rd, 32'h0);
        complete_run();
    end
endmodule : consumer_ir_modem_config_tb
`default_nettype wire
